// ===== hdl/lvs_top.sv
// Low-voltage supervisor: control, reset sequencing, flags and AXI4-Lite registers
// What this block does
// - Detection is active only while detect_enable is set.
// - detect_trip_select picks high or low trip level, driven to the comparator.
// - In any stop mode detection turns off unless detect_stop_enable is set.
// - With detect and stop enables set, deep stops are replaced by shallow_stop.
// - Power-on detector holds system reset until supply rises above the low level.
// - Power-on reset sets both power-on and low_supply_cause flags.
// - With reset select set and detection active, a low supply causes reset.
// - A low-voltage reset holds until supply rises above the selected level.
// - low_supply_cause is set after every low-voltage or power-on reset.
// - Interrupt mode sets detect_flag and raises the interrupt, no reset.
// - supply_warning flags a supply near the trip level and never interrupts.
// - warning_trip_select picks the warning level, independent of detect level.
// - reset_cause_register is read-only; writes leave it unchanged.
//
// Decided for this implementation: the AXI4-Lite register port and the address map.
`timescale 1ns/1ns
module lvs_top (
  input  wire logic        aclk,               // Bus clock, 100 MHz
  input  wire logic        aresetn,            // Synchronous reset, active low
  input  wire logic [7:0]  s_axi_awaddr,       // Write address
  input  wire logic        s_axi_awvalid,      // Write address valid
  output logic             s_axi_awready,      // Write address ready
  input  wire logic [31:0] s_axi_wdata,        // Write data
  input  wire logic [3:0]  s_axi_wstrb,        // Write byte strobes
  input  wire logic        s_axi_wvalid,       // Write data valid
  output logic             s_axi_wready,       // Write data ready
  output logic [1:0]       s_axi_bresp,        // Write response
  output logic             s_axi_bvalid,       // Write response valid
  input  wire logic        s_axi_bready,       // Write response ready
  input  wire logic [7:0]  s_axi_araddr,       // Read address
  input  wire logic        s_axi_arvalid,      // Read address valid
  output logic             s_axi_arready,      // Read address ready
  output logic [31:0]      s_axi_rdata,        // Read data
  output logic [1:0]       s_axi_rresp,        // Read response
  output logic             s_axi_rvalid,       // Read data valid
  input  wire logic        s_axi_rready,       // Read data ready
  input  wire logic        por_detect,         // Power-on detector, async
  input  wire logic        below_high_level,   // Supply below high_detect_level, async
  input  wire logic        below_low_level,    // Supply below low_detect_level, async
  input  wire logic        below_warning,      // Supply below warning level, async
  input  wire logic        stop_request,       // Core asks for stop, level
  input  wire logic [1:0]  stop_select,        // Stop mode asked for
  output logic             detect_active,      // Comparator enable
  output logic             detect_trip_level,  // 1 selects high trip level
  output logic             warning_trip_level, // 1 selects high warning level
  output logic             stop_granted,       // Stop mode entered
  output logic [1:0]       stop_mode,          // Stop mode granted
  output logic             sys_reset,          // System reset, active high
  output logic             irq                 // Low-voltage interrupt, level
);

  // ==========================================================
  // State record
  typedef struct packed {
    logic                    awready;
    logic                    wready;
    logic                    aw_full;
    logic                    w_full;
    logic [7:0]              waddr;
    logic [7:0]              wbyte;
    logic                    wlane;
    logic                    bvalid;
    logic [1:0]              bresp;
    logic                    arready;
    logic                    rvalid;
    logic [1:0]              rresp;
    logic [31:0]             rdata;
    logic                    detect_enable;
    logic                    detect_stop_enable;
    logic                    detect_reset_select;
    logic                    detect_irq_enable;
    logic                    detect_trip_select;
    logic                    warning_trip_select;
    logic [7:0]              cause;
    logic                    detect_flag;
    logic                    supply_warning;
    lvs_pkg::lvs_rst_state_t rst_state;
    logic                    sys_reset;
    logic                    irq;
    logic                    active;
    logic                    in_stop;
    logic [1:0]              stop_mode;
  } lvs_state_t;

  lvs_state_t s;
  lvs_state_t next_s;
  logic [3:0] cmp_sync;
  logic       por_s;
  logic       below_high_s;
  logic       below_low_s;
  logic       warn_s;
  logic       below_sel;
  logic       low_trigger;
  logic       wr_go;

  // ==========================================================
  // Comparator sync; the two trip levels enter inverted so a cleared stage reads as below, not above
  lvs_sync #(
    .WIDTH (4)
  ) u_sync (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .async_in ({por_detect, ~below_high_level, ~below_low_level, below_warning}),
    .sync_out (cmp_sync)
  );

  assign por_s        = cmp_sync[3];
  assign below_high_s = !cmp_sync[2];
  assign below_low_s  = !cmp_sync[1];
  assign warn_s       = cmp_sync[0];

  // ==========================================================
  // Address decode shared by the read and write paths
  function automatic logic is_mapped(input logic [7:0] addr);
    is_mapped = (addr == lvs_pkg::OFF_PWR_ONE) || (addr == lvs_pkg::OFF_PWR_TWO) ||
                (addr == lvs_pkg::OFF_CAUSE)   || (addr == lvs_pkg::OFF_STATUS)  ||
                (addr == lvs_pkg::OFF_MASK)    || (addr == lvs_pkg::OFF_LIVE);
  endfunction

  function automatic logic [31:0] read_value(input logic [7:0] addr, input lvs_state_t st);
    logic [7:0] v;
    v = 8'h00;
    case (addr)
      lvs_pkg::OFF_PWR_ONE:
      begin
        v[lvs_pkg::PC1_DETECT_ENABLE] = st.detect_enable;
        v[lvs_pkg::PC1_STOP_ENABLE]   = st.detect_stop_enable;
        v[lvs_pkg::PC1_RESET_SELECT]  = st.detect_reset_select;
        v[lvs_pkg::PC1_IRQ_ENABLE]    = st.detect_irq_enable;
      end
      lvs_pkg::OFF_PWR_TWO:
      begin
        v[lvs_pkg::PC2_DETECT_TRIP]  = st.detect_trip_select;
        v[lvs_pkg::PC2_WARNING_TRIP] = st.warning_trip_select;
      end
      lvs_pkg::OFF_CAUSE: v = st.cause;
      lvs_pkg::OFF_STATUS:
      begin
        v[lvs_pkg::ST_DETECT]  = st.detect_flag;
        v[lvs_pkg::ST_WARNING] = st.supply_warning;
      end
      lvs_pkg::OFF_MASK: v[lvs_pkg::ST_DETECT] = st.detect_irq_enable;
      lvs_pkg::OFF_LIVE:
      begin
        v[lvs_pkg::LIVE_ACTIVE]  = st.active;
        v[lvs_pkg::LIVE_BELOW]   = st.detect_trip_select ? below_high_s : below_low_s;
        v[lvs_pkg::LIVE_WARN]    = warn_s;
        v[lvs_pkg::LIVE_IN_STOP] = st.in_stop;
        v[lvs_pkg::LIVE_RESET]   = st.sys_reset;
      end
      default: v = 8'h00;
    endcase
    read_value = {24'h000000, v};
  endfunction

  // Level compared against follows the live trip selection
  assign below_sel   = s.detect_trip_select ? below_high_s : below_low_s;
  assign low_trigger = s.active && s.detect_reset_select && below_sel;
  assign wr_go       = s.aw_full && s.w_full && !s.bvalid;

  // ==========================================================
  // Next-state logic
  always_comb
  begin
    next_s = s;

    // Write address and data are taken independently
    if (s_axi_awvalid && s.awready)
    begin
      next_s.aw_full = 1'b1;
      next_s.waddr   = s_axi_awaddr;
    end
    if (s_axi_wvalid && s.wready)
    begin
      next_s.w_full = 1'b1;
      next_s.wbyte  = s_axi_wdata[7:0];
      next_s.wlane  = s_axi_wstrb[0];
    end
    if (s.bvalid && s_axi_bready)
      next_s.bvalid = 1'b0;

    // Register writes; clears go first so a same-cycle hardware set wins
    if (wr_go)
    begin
      next_s.aw_full = 1'b0;
      next_s.w_full  = 1'b0;
      next_s.bvalid  = 1'b1;
      next_s.bresp   = is_mapped(s.waddr) ? lvs_pkg::RESP_OKAY : lvs_pkg::RESP_SLVERR;
      if (s.wlane)
      begin
        case (s.waddr)
          lvs_pkg::OFF_PWR_ONE:
          begin
            next_s.detect_enable       = s.wbyte[lvs_pkg::PC1_DETECT_ENABLE];
            next_s.detect_stop_enable  = s.wbyte[lvs_pkg::PC1_STOP_ENABLE];
            next_s.detect_reset_select = s.wbyte[lvs_pkg::PC1_RESET_SELECT];
            next_s.detect_irq_enable   = s.wbyte[lvs_pkg::PC1_IRQ_ENABLE];
          end
          lvs_pkg::OFF_PWR_TWO:
          begin
            next_s.detect_trip_select  = s.wbyte[lvs_pkg::PC2_DETECT_TRIP];
            next_s.warning_trip_select = s.wbyte[lvs_pkg::PC2_WARNING_TRIP];
          end
          lvs_pkg::OFF_STATUS:
          begin
            if (s.wbyte[lvs_pkg::ST_DETECT])
              next_s.detect_flag = 1'b0;
            if (s.wbyte[lvs_pkg::ST_WARNING])
              next_s.supply_warning = 1'b0;
          end
          lvs_pkg::OFF_MASK: next_s.detect_irq_enable = s.wbyte[lvs_pkg::ST_DETECT];
          default: next_s.cause = s.cause; // Cause and live registers ignore writes
        endcase
      end
    end
    next_s.awready = !next_s.aw_full;
    next_s.wready  = !next_s.w_full;

    // Reads answer one cycle after the address is taken
    if (s.rvalid && s_axi_rready)
      next_s.rvalid = 1'b0;
    if (s_axi_arvalid && s.arready)
    begin
      next_s.rvalid = 1'b1;
      next_s.rdata  = read_value(s_axi_araddr, s);
      next_s.rresp  = is_mapped(s_axi_araddr) ? lvs_pkg::RESP_OKAY : lvs_pkg::RESP_SLVERR;
    end
    next_s.arready = !next_s.rvalid;

    // Interrupt mode: flag instead of reset
    if (s.rst_state == lvs_pkg::LVS_RUN && s.active && !s.detect_reset_select && below_sel)
      next_s.detect_flag = 1'b1;
    // Warning is a polled flag only
    if (warn_s)
      next_s.supply_warning = 1'b1;

    // System reset sequencer
    unique case (s.rst_state)
      lvs_pkg::LVS_RUN:
      begin
        if (por_s)
        begin
          next_s.rst_state = lvs_pkg::LVS_POR_HOLD;
          next_s.cause     = lvs_pkg::RST_CAUSE;
        end
        else if (low_trigger)
        begin
          next_s.rst_state = lvs_pkg::LVS_LOW_HOLD;
          next_s.cause = s.cause & (8'h01 << lvs_pkg::CAUSE_POWER_ON);
          next_s.cause[lvs_pkg::CAUSE_LOW_SUPPLY] = 1'b1;
        end
      end
      lvs_pkg::LVS_POR_HOLD:
      begin
        if (por_s)
          next_s.cause = lvs_pkg::RST_CAUSE;
        else if (!below_low_s)
          next_s.rst_state = lvs_pkg::LVS_RUN;
      end
      lvs_pkg::LVS_LOW_HOLD:
      begin
        if (por_s)
        begin
          next_s.rst_state = lvs_pkg::LVS_POR_HOLD;
          next_s.cause     = lvs_pkg::RST_CAUSE;
        end
        else if (!below_sel)
          next_s.rst_state = lvs_pkg::LVS_RUN;
      end
    endcase
    next_s.sys_reset = (next_s.rst_state != lvs_pkg::LVS_RUN);

    // Stop handling: deep stops refused while detection must stay on
    next_s.in_stop = stop_request;
    if (!stop_request)
      next_s.stop_mode = lvs_pkg::STOP_NONE;
    else if (s.detect_enable && s.detect_stop_enable)
      next_s.stop_mode = lvs_pkg::STOP_SHALLOW;
    else
      next_s.stop_mode = stop_select;

    // Comparator enable follows control and stop state
    next_s.active = next_s.detect_enable &&
                    (!next_s.in_stop || next_s.detect_stop_enable);
    next_s.irq = next_s.detect_flag && next_s.detect_irq_enable;
  end

  // ==========================================================
  // State register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s                     <= '0;
      s.awready             <= 1'b1;
      s.wready              <= 1'b1;
      s.arready             <= 1'b1;
      s.detect_enable       <= lvs_pkg::RST_DETECT_ENABLE;
      s.detect_stop_enable  <= lvs_pkg::RST_STOP_ENABLE;
      s.detect_reset_select <= lvs_pkg::RST_RESET_SELECT;
      s.detect_irq_enable   <= lvs_pkg::RST_IRQ_ENABLE;
      s.detect_trip_select  <= lvs_pkg::RST_DETECT_TRIP;
      s.warning_trip_select <= lvs_pkg::RST_WARNING_TRIP;
      s.cause               <= lvs_pkg::RST_CAUSE;
      s.rst_state           <= lvs_pkg::LVS_POR_HOLD;
      s.sys_reset           <= 1'b1;
    end
    else
      s <= next_s;
  end

  // ==========================================================
  // Outputs, all straight from the state record
  assign s_axi_awready      = s.awready;
  assign s_axi_wready       = s.wready;
  assign s_axi_bresp        = s.bresp;
  assign s_axi_bvalid       = s.bvalid;
  assign s_axi_arready      = s.arready;
  assign s_axi_rdata        = s.rdata;
  assign s_axi_rresp        = s.rresp;
  assign s_axi_rvalid       = s.rvalid;
  assign detect_active      = s.active;
  assign detect_trip_level  = s.detect_trip_select;
  assign warning_trip_level = s.warning_trip_select;
  assign stop_granted       = s.in_stop;
  assign stop_mode          = s.stop_mode;
  assign sys_reset          = s.sys_reset;
  assign irq                = s.irq;

  // ==========================================================
  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_ACTIVE_NEEDS_ENABLE: assert property (!s.detect_enable |-> !detect_active)
    else $error("detection active while disabled");

  AST_TRIP_FOLLOWS_WRITE: assert property (
    (wr_go && s.wlane && s.waddr == lvs_pkg::OFF_PWR_TWO)
    |=> detect_trip_level == $past(s.wbyte[lvs_pkg::PC2_DETECT_TRIP]))
    else $error("trip level did not follow the write");

  AST_STOP_TURNS_OFF: assert property (
    (stop_granted && !s.detect_stop_enable) |-> !detect_active)
    else $error("detection left on in stop");

  AST_STOP_SHALLOW_ONLY: assert property (
    (stop_request && s.detect_enable && s.detect_stop_enable)
    |=> stop_granted && stop_mode == lvs_pkg::STOP_SHALLOW)
    else $error("deep stop granted while detection must stay on");

  AST_POR_HOLD: assert property (
    (s.rst_state == lvs_pkg::LVS_POR_HOLD && below_low_s)
    |=> sys_reset && s.rst_state == lvs_pkg::LVS_POR_HOLD)
    else $error("power-on reset released below the low level");

  AST_POR_FLAGS: assert property (
    por_s |=> s.cause[lvs_pkg::CAUSE_POWER_ON] && s.cause[lvs_pkg::CAUSE_LOW_SUPPLY])
    else $error("power-on cause flags not set");

  AST_LOW_RESET: assert property (
    (s.rst_state == lvs_pkg::LVS_RUN && low_trigger && !por_s)
    |=> sys_reset && s.rst_state == lvs_pkg::LVS_LOW_HOLD)
    else $error("low supply did not reset");

  AST_LOW_HOLD: assert property (
    (s.rst_state == lvs_pkg::LVS_LOW_HOLD && below_sel) |=> sys_reset)
    else $error("low-voltage reset released below the selected level");

  AST_LOW_CAUSE: assert property (
    $rose(s.rst_state == lvs_pkg::LVS_LOW_HOLD) |-> s.cause[lvs_pkg::CAUSE_LOW_SUPPLY])
    else $error("low supply cause flag not set");

  AST_FLAG_INSTEAD: assert property (
    (s.rst_state == lvs_pkg::LVS_RUN && !por_s && s.active && !s.detect_reset_select && below_sel)
    |=> s.detect_flag && s.rst_state == lvs_pkg::LVS_RUN)
    else $error("interrupt-mode detection did not set the flag");

  AST_WARN_NO_IRQ: assert property ((s.supply_warning && !s.detect_flag) |-> !irq)
    else $error("warning raised an interrupt");

  AST_CAUSE_READ_ONLY: assert property (
    (wr_go && s.waddr == lvs_pkg::OFF_CAUSE && s.rst_state == lvs_pkg::LVS_RUN
     && !por_s && !low_trigger) |=> $stable(s.cause))
    else $error("write changed the reset cause register");

  AST_IRQ_LEVEL: assert property (irq == (s.detect_flag && s.detect_irq_enable))
    else $error("interrupt does not match flag and enable");

  COV_LOW_RESET: cover property ($rose(s.rst_state == lvs_pkg::LVS_LOW_HOLD));
  COV_IRQ: cover property ($rose(irq) ##[1:50] !irq);
  COV_STOP_DOWNGRADE: cover property (stop_granted && stop_mode == lvs_pkg::STOP_SHALLOW
                                      && stop_select == lvs_pkg::STOP_DEEPEST);

endmodule

// ===== common/lvs_pkg.sv
// Constants shared by the low-voltage supervisor design files
package lvs_pkg;

  // ==========================================================
  // Register map (byte addresses on the AXI4-Lite bus)
  localparam int unsigned ADDR_W      = 8;
  localparam logic [7:0]  OFF_PWR_ONE = 8'h00;
  localparam logic [7:0]  OFF_PWR_TWO = 8'h04;
  localparam logic [7:0]  OFF_CAUSE   = 8'h08;
  localparam logic [7:0]  OFF_STATUS  = 8'h0C;
  localparam logic [7:0]  OFF_MASK    = 8'h10;
  localparam logic [7:0]  OFF_LIVE    = 8'h14;

  // ==========================================================
  // Field positions
  localparam int unsigned PC1_DETECT_ENABLE = 0;
  localparam int unsigned PC1_STOP_ENABLE   = 1;
  localparam int unsigned PC1_RESET_SELECT  = 2;
  localparam int unsigned PC1_IRQ_ENABLE    = 3;
  localparam int unsigned PC2_DETECT_TRIP   = 0;
  localparam int unsigned PC2_WARNING_TRIP  = 1;
  localparam int unsigned CAUSE_LOW_SUPPLY  = 1;
  localparam int unsigned CAUSE_POWER_ON    = 7;
  localparam int unsigned ST_DETECT         = 0;
  localparam int unsigned ST_WARNING        = 1;
  localparam int unsigned LIVE_ACTIVE       = 0;
  localparam int unsigned LIVE_BELOW        = 1;
  localparam int unsigned LIVE_WARN         = 2;
  localparam int unsigned LIVE_IN_STOP      = 3;
  localparam int unsigned LIVE_RESET        = 4;

  // ==========================================================
  // Reset values
  localparam logic       RST_DETECT_ENABLE = 1'h1;
  localparam logic       RST_STOP_ENABLE   = 1'h0;
  localparam logic       RST_RESET_SELECT  = 1'h1;
  localparam logic       RST_IRQ_ENABLE    = 1'h0;
  localparam logic       RST_DETECT_TRIP   = 1'h0;
  localparam logic       RST_WARNING_TRIP  = 1'h0;
  localparam logic [7:0] RST_CAUSE         = 8'h82;

  // ==========================================================
  // Bus responses and stop mode codes
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] STOP_NONE    = 2'h0;
  localparam logic [1:0] STOP_DEEPEST = 2'h1;
  localparam logic [1:0] STOP_MIDDLE  = 2'h2;
  localparam logic [1:0] STOP_SHALLOW = 2'h3;

  // ==========================================================
  // System reset sequencer states
  typedef enum logic [1:0] {LVS_RUN, LVS_POR_HOLD, LVS_LOW_HOLD} lvs_rst_state_t;

endpackage

// ===== hdl/lvs_sync.sv
// Two-stage synchroniser for the asynchronous comparator outputs
`timescale 1ns/1ns
module lvs_sync #(
  parameter int unsigned WIDTH = 4
) (
  input  wire logic             aclk,     // Bus clock
  input  wire logic             aresetn,  // Synchronous reset, active low
  input  wire logic [WIDTH-1:0] async_in, // Levels from the analogue side
  output logic      [WIDTH-1:0] sync_out  // Levels safe for bus-clock logic
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } lvs_sync_state_t;

  lvs_sync_state_t s;
  lvs_sync_state_t next_s;

  // ==========================================================
  // Stage chain; the first stage feeds only the second
  always_comb
  begin
    next_s.meta   = async_in;
    next_s.stable = s.meta;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      s <= '0;
    else
      s <= next_s;
  end

  assign sync_out = s.stable;

  // ==========================================================
  // Checks
  AST_SYNC_TWO_STAGES: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(aresetn, 2) |-> sync_out == $past(async_in, 2))
    else $error("synchroniser latency is not two cycles");

endmodule

// ===== verification/lvs_top_test.sv
// Self-checking bench for the low-voltage supervisor
`timescale 1ns/1ns
module lvs_top_test;
  // ==========================================================
  // Signals
  logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
  logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, stop_select, stop_mode, resp;
  logic        por_detect, below_high_level, below_low_level, below_warning;
  logic        stop_request, detect_active, detect_trip_level, warning_trip_level;
  logic        stop_granted, sys_reset, irq;
  int          error_cnt, tests_run, m;

  lvs_top dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .por_detect,
    .below_high_level, .below_low_level, .below_warning, .stop_request,
    .stop_select, .detect_active, .detect_trip_level, .warning_trip_level,
    .stop_granted, .stop_mode, .sys_reset, .irq);

  // ==========================================================
  // Shared tasks
  task summarize;
    $display("Checks %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("ERROR at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  // A wait that ran out counts as a mismatch and ends the run
  task tmo;
    chk(32'h0, 32'h1);
    summarize();
  endtask
  task cyc(input int k);
    repeat (k) @(posedge aclk);
  endtask
  // Bus write: both channels offered together, each released when taken
  task wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid  <= 1'h1;
    s_axi_bready  <= 1'h1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid === 1'h1) break;
    end
    s_axi_bready <= 1'h0;
    resp = s_axi_bresp;
    if (n == 50) tmo();
  endtask
  // Bus read: data and response taken at the edge that shows rvalid
  task rdw(input logic [7:0] a);
    int n;
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready  <= 1'h1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid === 1'h1) break;
    end
    s_axi_rready <= 1'h0;
    rd = s_axi_rdata;
    resp = s_axi_rresp;
    if (n == 50) tmo();
  endtask

  // ==========================================================
  // Scenarios
  task t_por;
    cyc(8);
    chk(sys_reset, 32'h1);
    below_low_level <= 1'h0;
    cyc(6);
    chk(sys_reset, 32'h0);
    rdw(lvs_pkg::OFF_CAUSE);
    chk(rd, 32'h82);
    wr(lvs_pkg::OFF_CAUSE, 32'h0);
    chk(resp, lvs_pkg::RESP_OKAY);
    rdw(lvs_pkg::OFF_CAUSE);
    chk(rd, 32'h82);
    rdw(8'h40);
    chk(resp, lvs_pkg::RESP_SLVERR);
    wr(8'h40, 32'h1);
    chk(resp, lvs_pkg::RESP_SLVERR);
    $display("t_por done");
  endtask
  task t_ctrl;
    rdw(lvs_pkg::OFF_PWR_ONE);
    chk(rd, 32'h5);
    wr(lvs_pkg::OFF_PWR_TWO, 32'h3);
    cyc(2);
    chk({detect_trip_level, warning_trip_level}, 32'h3);
    wr(lvs_pkg::OFF_PWR_TWO, 32'h2);
    cyc(2);
    chk({detect_trip_level, warning_trip_level}, 32'h1);
    // Detection off: a low supply must not reset
    wr(lvs_pkg::OFF_PWR_ONE, 32'h4);
    below_low_level <= 1'h1;
    cyc(6);
    chk({detect_active, sys_reset}, 32'h0);
    below_low_level <= 1'h0;
    wr(lvs_pkg::OFF_PWR_ONE, 32'h5);
    cyc(2);
    chk(detect_active, 32'h1);
    $display("t_ctrl done");
  endtask
  task t_stop;
    stop_select  <= lvs_pkg::STOP_DEEPEST;
    stop_request <= 1'h1;
    cyc(3);
    chk({stop_granted, stop_mode, detect_active}, 32'hA);
    stop_request <= 1'h0;
    wr(lvs_pkg::OFF_PWR_ONE, 32'h7);
    // Every stop mode collapses to the shallow one, detection kept on
    for (m = 1; m < 4; m++)
    begin
      stop_select  <= m[1:0];
      stop_request <= 1'h1;
      cyc(3);
      chk({stop_mode, detect_active}, 32'h7);
      stop_request <= 1'h0;
      cyc(2);
    end
    wr(lvs_pkg::OFF_PWR_ONE, 32'h5);
    $display("t_stop done");
  endtask
  task t_lvr;
    wr(lvs_pkg::OFF_PWR_TWO, 32'h1);
    below_high_level <= 1'h1;
    cyc(3);
    chk(sys_reset, 32'h0);
    cyc(3);
    chk(sys_reset, 32'h1);
    cyc(6);
    chk(sys_reset, 32'h1);
    below_high_level <= 1'h0;
    cyc(6);
    chk(sys_reset, 32'h0);
    rdw(lvs_pkg::OFF_CAUSE);
    chk(rd, 32'h82);
    $display("t_lvr done");
  endtask
  // Power-on detector fires mid-run; hold lasts until above the low level
  task t_pwr;
    por_detect      <= 1'h1;
    below_low_level <= 1'h1;
    cyc(4);
    chk(sys_reset, 32'h1);
    por_detect <= 1'h0;
    cyc(6);
    chk(sys_reset, 32'h1);
    below_low_level <= 1'h0;
    cyc(6);
    chk(sys_reset, 32'h0);
    rdw(lvs_pkg::OFF_CAUSE);
    chk(rd, 32'h82);
    $display("t_pwr done");
  endtask
  task t_irq;
    wr(lvs_pkg::OFF_PWR_ONE, 32'h9);
    below_high_level <= 1'h1;
    cyc(6);
    chk({irq, sys_reset}, 32'h2);
    below_high_level <= 1'h0;
    rdw(lvs_pkg::OFF_STATUS);
    chk(rd, 32'h1);
    // Masking hides the level, unmasking brings it back while flag stays
    wr(lvs_pkg::OFF_MASK, 32'h0);
    cyc(2);
    chk(irq, 32'h0);
    wr(lvs_pkg::OFF_MASK, 32'h1);
    cyc(2);
    chk(irq, 32'h1);
    wr(lvs_pkg::OFF_STATUS, 32'h1);
    cyc(2);
    chk(irq, 32'h0);
    below_warning <= 1'h1;
    cyc(6);
    rdw(lvs_pkg::OFF_STATUS);
    chk({rd[30:0], irq}, 32'h4);
    below_warning <= 1'h0;
    $display("t_irq done");
  endtask

  // ==========================================================
  // Clock and main sequence
  initial
  begin
    aclk = 1'h0;
    forever #5 aclk = ~aclk;
  end
  initial
  begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 5'h0;
    {s_axi_rready, por_detect, below_high_level, below_warning} = 4'h0;
    {stop_request, stop_select, s_axi_awaddr, s_axi_araddr} = 19'h0;
    s_axi_wdata     = 32'h0;
    s_axi_wstrb     = 4'hF;
    below_low_level = 1'h1;
    error_cnt       = 0;
    tests_run       = 0;
    cyc(10);
    aresetn <= 1'h1;
    t_por();
    t_ctrl();
    t_stop();
    t_lvr();
    t_pwr();
    t_irq();
    summarize();
  end
endmodule
